//--- inc/ssc_pkg.sv
// socket status-change event block: shared offsets, field positions, reset values
// assumes a 32-bit register port decoded against a per-socket base address
package ssc_pkg;
  // ----------------------------------------------------------------
  // register offsets within the socket window
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_FLAGS = 12'h000;
  localparam logic [11:0] OFF_ENABLES = 12'h004;
  localparam logic [11:0] OFF_CONDITION = 12'h008;
  localparam logic [11:0] OFF_INJECTION = 12'h00c;
  localparam logic [11:0] OFF_SETTINGS = 12'h010;
  localparam logic [11:0] OFF_POWER_SETTINGS = 12'h020;
  localparam int WIN_BITS = 12;
  // ----------------------------------------------------------------
  // event bit positions (flags, enables, injection, condition)
  // ----------------------------------------------------------------
  localparam int BIT_CARD_STATUS = 0;
  localparam int BIT_DETECT_ONE = 1;
  localparam int BIT_DETECT_TWO = 2;
  localparam int BIT_POWER = 3;
  localparam int NUM_EVENTS = 4;
  localparam int BIT_CARDBUS = 5;
  localparam int BIT_SIXTEEN = 4;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] ENABLES_RESET = 4'h0;
  localparam logic [31:0] SETTINGS_RESET = 32'h0000_0000;
  localparam logic [31:0] POWER_SETTINGS_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
endpackage

//--- logic/ssc_events.sv
// socket status-change event flags, enables and interrupt request
// assumes a simple single-cycle register port already qualified by the socket base decode
//
// Function
// - flags record change only, not direction
// - write one clears flag, zero keeps
// - injection write one sets matching flag
// - bus reset clears every flag
// - flags may set again after card reset
// - pending flag interrupts once enabled
// - flag 3 on power state change
// - flag 2 on detect two change
// - flag 1 on detect one change
// - flag 0 on card status change
// - cardbus card: rising edge only
// - sixteen-bit card: both edges
// - flag register bits 31:4 read zero
// - enables gate interrupt only, not flags
// - enable 3 gates power change interrupt
// - detect enable field 00 blocks, 11 allows
// - enable 0 gates card status interrupt
// - enable register bits 31:4 read zero
// - registers decoded at offsets from base
// - each socket has own base address
// - detect changes during identification flagged once it ends
// - power state reads 0 down, 1 up
`timescale 1ns/1ps
module ssc_events
  import ssc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  // register port, one access per strobe
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ssc_pkg::WIN_BITS-1:0] reg_offset,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // socket pins and socket status from card logic
  input wire logic card_status_pin,
  input wire logic detect_one_n_pin,
  input wire logic detect_two_n_pin,
  input wire logic socket_powered,
  input wire logic card_ident_busy,
  input wire logic cardbus_card,
  input wire logic sixteen_bit_card,
  // outputs
  output logic status_change_interrupt,
  output logic [3:0] socket_change_flags,
  output logic [31:0] socket_settings,
  output logic [31:0] socket_power_settings
);
  import ssc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [5:0] pins_s;
  ssc_sync #(
    .WIDTH(6)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({sixteen_bit_card, cardbus_card, card_ident_busy, socket_powered,
      detect_two_n_pin, detect_one_n_pin}),
    .sync_out(pins_s)
  );
  logic card_status_s;
  ssc_sync #(
    .WIDTH(1)
  ) u_sync_sts (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(card_status_pin),
    .sync_out(card_status_s)
  );

  // ----------------------------------------------------------------
  // present-state levels
  // ----------------------------------------------------------------
  logic [3:0] level_q;
  logic [3:0] level_prev_q;
  logic [3:0] inject_q;
  logic idle_q;
  logic [3:0] flags_q;
  logic [3:0] enables_q;
  logic [31:0] settings_q;
  logic [31:0] power_settings_q;
  logic [3:0] change;
  logic [3:0] clear_bits;
  logic wr_flags;
  logic wr_inject;

  assign wr_flags = reg_sel && reg_wr && (reg_offset == OFF_FLAGS);
  assign wr_inject = reg_sel && reg_wr && (reg_offset == OFF_INJECTION);
  assign clear_bits = wr_flags ? reg_wdata[NUM_EVENTS-1:0] : 4'h0;

  // detect lines are frozen while identification runs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      level_q <= 4'h0;
      idle_q <= 1'b1;
    end else begin
      idle_q <= 1'b0;
      level_q[BIT_CARD_STATUS] <= card_status_s;
      level_q[BIT_POWER] <= pins_s[2];
      if (!pins_s[3]) begin
        level_q[BIT_DETECT_ONE] <= pins_s[0];
        level_q[BIT_DETECT_TWO] <= pins_s[1];
      end
    end
  end

  // previous levels; held equal during the first cycle so reset makes no event
  always_ff @(posedge core_clk) begin
    if (rst) begin
      level_prev_q <= 4'h0;
    end else begin
      level_prev_q <= level_q;
    end
  end

  // detect and power levels reset to 0, but an empty socket reads its detect pins high;
  // their change events wait until the synchroniser and level stages hold real pin values.
  // limitation: a real detect or power change inside this short window is not flagged
  logic [3:0] settle_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      settle_q <= 4'hf;
    end else begin
      settle_q <= {settle_q[2:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // change detection, per event bit
  // ----------------------------------------------------------------
  // only "something changed" is kept; direction is dropped
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_change
      if (gi == BIT_CARD_STATUS) begin : g_sts
        logic rise;
        logic fall;
        assign rise = level_q[gi] && !level_prev_q[gi];
        assign fall = !level_q[gi] && level_prev_q[gi];
        // cardbus counts rising edges only, 16-bit both edges
        assign change[gi] = !idle_q && ((pins_s[4] && rise)
          || (pins_s[5] && (rise || fall)));
      end else begin : g_lvl
        assign change[gi] = !settle_q[3] && (level_q[gi] != level_prev_q[gi]);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // flags: set beats clear, reset clears all
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_q <= FLAGS_RESET;
    end else begin
      // status still asserted after card reset simply sets again here
      flags_q <= (flags_q & ~clear_bits) | change | inject_q;
    end
  end

  // injection write lands one cycle later, like a real status change
  always_ff @(posedge core_clk) begin
    if (rst) begin
      inject_q <= 4'h0;
    end else begin
      inject_q <= wr_inject ? reg_wdata[NUM_EVENTS-1:0] : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enables_q <= ENABLES_RESET;
      settings_q <= SETTINGS_RESET;
      power_settings_q <= POWER_SETTINGS_RESET;
    end else if (reg_sel && reg_wr) begin
      case (reg_offset)
        OFF_ENABLES: begin
          enables_q <= reg_wdata[NUM_EVENTS-1:0];
        end
        OFF_SETTINGS: begin
          settings_q <= reg_wdata;
        end
        OFF_POWER_SETTINGS: begin
          power_settings_q <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // reserved detect codes 01/10 are treated as blocking: only 11 allows
  logic [3:0] gate;
  assign gate[BIT_POWER] = enables_q[BIT_POWER];
  assign gate[BIT_DETECT_TWO] = &enables_q[BIT_DETECT_TWO:BIT_DETECT_ONE];
  assign gate[BIT_DETECT_ONE] = &enables_q[BIT_DETECT_TWO:BIT_DETECT_ONE];
  assign gate[BIT_CARD_STATUS] = enables_q[BIT_CARD_STATUS];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_change_interrupt <= 1'b0;
    end else begin
      // level, so flags left pending fire as soon as enabled
      status_change_interrupt <= |(flags_q & gate);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= READ_UNMAPPED;
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= reg_sel && (reg_rd || reg_wr);
      reg_rdata <= READ_UNMAPPED;
      if (reg_sel && reg_rd) begin
        case (reg_offset)
          OFF_FLAGS: begin
            reg_rdata <= {28'h0000000, flags_q};
          end
          OFF_ENABLES: begin
            reg_rdata <= {28'h0000000, enables_q};
          end
          OFF_CONDITION: begin
            reg_rdata <= {26'h0000000, pins_s[4], pins_s[5], level_q};
          end
          OFF_SETTINGS: begin
            reg_rdata <= settings_q;
          end
          OFF_POWER_SETTINGS: begin
            reg_rdata <= power_settings_q;
          end
          default: begin
            reg_rdata <= READ_UNMAPPED;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      socket_change_flags <= FLAGS_RESET;
      socket_settings <= SETTINGS_RESET;
      socket_power_settings <= POWER_SETTINGS_RESET;
    end else begin
      socket_change_flags <= flags_q;
      socket_settings <= settings_q;
      socket_power_settings <= power_settings_q;
    end
  end
endmodule // ssc_events

//--- logic/ssc_sync.sv
// two-flop synchroniser for a group of socket pins
// assumes inputs are asynchronous to core_clk
`timescale 1ns/1ps
module ssc_sync #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // ssc_sync

//--- test/ssc_card_model.sv
// card in the socket: detect lines, card type and status-change line
// assumes the bench picks insertion, card type and status level
`timescale 1ns/1ps
module ssc_card_model (
  input wire logic present,
  input wire logic is_cardbus,
  input wire logic status_level,
  output logic card_status_pin,
  output logic detect_one_n_pin,
  output logic detect_two_n_pin,
  output logic cardbus_card,
  output logic sixteen_bit_card
);
  // detect lines are pulled up, so an empty socket reads high
  assign detect_one_n_pin = !present;
  assign detect_two_n_pin = !present;
  assign cardbus_card = present && is_cardbus;
  assign sixteen_bit_card = present && !is_cardbus;
  // status line is pulled down when no card drives it
  assign card_status_pin = present && status_level;
endmodule // ssc_card_model

//--- test/ssc_events_assertions.sv
// port-level checks of the status-change event block
// assumes it is bound to ssc_events and sees only its ports
`timescale 1ns/1ps
module ssc_events_assertions
  import ssc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ssc_pkg::WIN_BITS-1:0] reg_offset,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic status_change_interrupt,
  input wire logic [3:0] socket_change_flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic acc = reg_sel && (reg_wr || reg_rd);
  wire logic clr = reg_sel && reg_wr && reg_offset == OFF_FLAGS;
  wire logic rd_x = reg_sel && reg_rd;
  sequence s_inject; reg_sel && reg_wr && reg_offset == OFF_INJECTION; endsequence
  sequence s_clear; clr ##1 1'b1; endsequence
  property p_ack; acc |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge");
  property p_flag_hi; rd_x && reg_offset == OFF_FLAGS |=> reg_rdata[31:4] == 28'h0; endproperty
  a_flag_hi: assert property (p_flag_hi) else $error("flag upper bits set");
  property p_en_hi; rd_x && reg_offset == OFF_ENABLES |=> reg_rdata[31:4] == 28'h0; endproperty
  a_en_hi: assert property (p_en_hi) else $error("enable upper bits set");
  property p_inj_rd; rd_x && reg_offset == OFF_INJECTION |=> reg_rdata == 32'h0; endproperty
  a_inj_rd: assert property (p_inj_rd) else $error("injection reads nonzero");
  property p_inject;
    s_inject |-> ##3 (socket_change_flags & $past(reg_wdata[3:0], 3)) == $past(reg_wdata[3:0], 3);
  endproperty
  a_inject: assert property (p_inject) else $error("injected flag missing");
  property p_clear; s_clear |=> (socket_change_flags & $past(reg_wdata[3:0], 2)) == 4'h0; endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_irq; status_change_interrupt |-> socket_change_flags != 4'h0; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without flag");
  property p_rst; $fell(rst) |-> socket_change_flags == 4'h0 && !status_change_interrupt; endproperty
  a_rst: assert property (p_rst) else $error("state left after reset");
  // a flag only drops after a clearing write two cycles earlier
  property p_sticky; |($past(socket_change_flags) & ~socket_change_flags) |-> $past(clr, 2); endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped by itself");
endmodule // ssc_events_assertions
bind ssc_events ssc_events_assertions i_ssc_events_assertions (.core_clk(core_clk), .rst(rst),
  .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_offset(reg_offset),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .status_change_interrupt(status_change_interrupt), .socket_change_flags(socket_change_flags));

//--- test/tb_ssc_events.sv
// self-checking bench for the status-change event block
// assumes the card model stands on the socket side
`timescale 1ns/1ps
module tb_ssc_events;
  import ssc_pkg::*;
  logic core_clk = 0, rst = 1, reg_sel = 0, reg_wr = 0, reg_rd = 0;
  logic powered = 0, present = 0, is_cb = 1, sts = 0, ident = 0;
  logic [11:0] reg_offset = 12'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, q, settings, power_settings;
  logic reg_ack, irq, csp, d1n, d2n, cbc, sbc;
  logic [3:0] flags;
  logic [3:0] en_t [7] = '{4'h8, 4'h0, 4'h6, 4'h6, 4'h2, 4'h1, 4'he};
  logic [3:0] inj_t [7] = '{4'h8, 4'h8, 4'h6, 4'h1, 4'h4, 4'h1, 4'h1};
  logic [6:0] exp_t = 7'b0100101;
  int fail_count = 0, checks = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  ssc_card_model i_ssc_card_model (.present(present), .is_cardbus(is_cb), .status_level(sts),
    .card_status_pin(csp), .detect_one_n_pin(d1n), .detect_two_n_pin(d2n),
    .cardbus_card(cbc), .sixteen_bit_card(sbc));
  ssc_events i_ssc_events (.core_clk(core_clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_offset(reg_offset), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .card_status_pin(csp), .detect_one_n_pin(d1n), .detect_two_n_pin(d2n),
    .socket_powered(powered), .card_ident_busy(ident), .cardbus_card(cbc),
    .sixteen_bit_card(sbc), .status_change_interrupt(irq), .socket_change_flags(flags),
    .socket_settings(settings), .socket_power_settings(power_settings));
  // ----------------------------------------------------------------
  // shared steps
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one edge passes before the strobe rises, so calls never collide
  task automatic acc(input logic wr, input logic [11:0] off, input logic [31:0] d);
    wt(1);
    reg_sel = 1;
    reg_wr = wr;
    reg_rd = !wr;
    reg_offset = off;
    reg_wdata = d;
    wt(1);
    q = reg_rdata;
    chk(reg_ack, 1, "ack");
    reg_sel = 0;
    reg_wr = 0;
    reg_rd = 0;
  endtask
  task automatic rd(input logic [11:0] off, input logic [31:0] exp);
    acc(0, off, 32'h0);
    chk(q, exp, "read");
  endtask
  task automatic pin_case(input logic [31:0] exp);
    wt(10);
    rd(OFF_FLAGS, exp);
    chk(flags, exp, "flag port");
    acc(1, OFF_FLAGS, 32'hf);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(OFF_FLAGS, 32'h0);
    acc(1, OFF_ENABLES, 32'hffff_ffff);
    rd(OFF_ENABLES, 32'hf);
    acc(1, OFF_ENABLES, 32'h0);
    acc(1, OFF_SETTINGS, 32'ha5a5_5a5a);
    rd(OFF_SETTINGS, 32'ha5a5_5a5a);
    chk(settings, 32'ha5a5_5a5a, "settings port");
    acc(1, OFF_POWER_SETTINGS, 32'h5a5a_a5a5);
    rd(OFF_POWER_SETTINGS, 32'h5a5a_a5a5);
    chk(power_settings, 32'h5a5a_a5a5, "power settings port");
    rd(OFF_INJECTION, 32'h0);
    acc(1, OFF_CONDITION, 32'hffff_ffff);
    rd(OFF_CONDITION, 32'h6);
    acc(1, 12'h014, 32'hffff_ffff);
    rd(12'h014, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_inject;
    acc(1, OFF_INJECTION, 32'hffff_ffff);
    wt(3);
    rd(OFF_FLAGS, 32'hf);
    chk(irq, 0, "masked irq");
    acc(1, OFF_FLAGS, 32'h5);
    wt(2);
    rd(OFF_FLAGS, 32'ha);
    acc(1, OFF_FLAGS, 32'hf);
    $display("test inject done");
  endtask
  task automatic t_gate;
    for (int i = 0; i < 7; i++) begin
      acc(1, OFF_INJECTION, {28'h0, inj_t[i]});
      wt(3);
      acc(1, OFF_ENABLES, {28'h0, en_t[i]});
      wt(2);
      chk(irq, exp_t[i], "gated irq");
      acc(1, OFF_FLAGS, 32'hf);
      wt(3);
      chk(irq, 0, "irq drop");
      acc(1, OFF_ENABLES, 32'h0);
    end
    $display("test gate done");
  endtask
  task automatic t_pins;
    present = 1;
    pin_case(32'h6);
    sts = 1;
    pin_case(32'h1);
    sts = 0;
    pin_case(32'h0);
    is_cb = 0;
    sts = 1;
    pin_case(32'h1);
    sts = 0;
    pin_case(32'h1);
    powered = 1;
    wt(10);
    rd(OFF_CONDITION, 32'h18);
    pin_case(32'h8);
    powered = 0;
    pin_case(32'h8);
    ident = 1;
    wt(3);
    present = 0;
    wt(10);
    rd(OFF_FLAGS, 32'h0);
    rd(OFF_CONDITION, 32'h0);
    ident = 0;
    pin_case(32'h6);
    $display("test pins done");
  endtask
  task automatic t_reset;
    present = 1;
    acc(1, OFF_ENABLES, 32'hf);
    acc(1, OFF_INJECTION, 32'hf);
    wt(4);
    chk(irq, 1, "irq before reset");
    sts = 1;
    rst = 1;
    wt(2);
    rst = 0;
    rd(OFF_FLAGS, 32'h0);
    chk(irq, 0, "irq after reset");
    rd(OFF_ENABLES, 32'h0);
    wt(10);
    rd(OFF_FLAGS, 32'h1);
    acc(1, OFF_FLAGS, 32'hf);
    $display("test reset done");
  endtask
  task give_verdict;
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    wt(2);
    rst = 0;
    t_regs;
    t_inject;
    t_gate;
    t_pins;
    t_reset;
    give_verdict;
  end
endmodule // tb_ssc_events
